// File: hw/pioc_port_bank.sv
// Purpose: port configuration for ports a to c; data latches and pin control for ports b to d
// Assumes: core drives a byte register bus on clk_i; pins are asynchronous
// Notes:   read data appears the cycle after the read strobe
// Contract
// - skip bit one makes the crossbar pass over that pin.
// - data writes latch; pins drive latched value where crossbar allows.
// - open-drain pin with latched one is left undriven.
// - data read returns one for analog pins.
// - data read returns sampled pin level for digital pins.
// - input-mode zero makes pin analog: no pullup, driver or receiver.
// - output-mode bit ignored on analog pins.
// - digital pins: output-mode zero open-drain, one push-pull.
// - of port c, only bits zero to three join the crossbar.
// - port d latch drives pins directly, no crossbar.
// - port d pins are bits zero to four, or bit zero only.
// - read-modify-write reads return the latch, not the pins.
// - all output drivers off while crossbar enable is clear.
`timescale 1ns/10ps
`include "pioc_defines.svh"
module pioc_port_bank #(
    parameter logic [7:0] PORT_B_PIN_MASK = `PIOC_ALL_PIN_MASK,
    parameter logic [7:0] PORT_D_PIN_MASK = `PIOC_PORT_D_PIN_MASK
) (
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic [7:0]           sfr_addr_i,
    input  wire logic                 sfr_wr_i,
    input  wire pioc_pkg::pioc_byte_t sfr_wdata_i,
    input  wire logic                 sfr_rd_i,
    input  wire logic                 sfr_rmw_i,
    output pioc_pkg::pioc_byte_t      sfr_rdata_o,
    output logic                      sfr_hit_o,
    input  wire logic                 crossbar_enable_bit_i,
    input  wire pioc_pkg::pioc_byte_t port_d_input_mode_i,
    input  wire pioc_pkg::pioc_byte_t port_d_output_mode_i,
    input  wire pioc_pkg::pioc_byte_t port_b_periph_sel_i,
    input  wire pioc_pkg::pioc_byte_t port_b_periph_dout_i,
    input  wire pioc_pkg::pioc_byte_t port_c_periph_sel_i,
    input  wire pioc_pkg::pioc_byte_t port_c_periph_dout_i,
    input  wire pioc_pkg::pioc_byte_t port_b_pin_i,
    input  wire pioc_pkg::pioc_byte_t port_c_pin_i,
    input  wire pioc_pkg::pioc_byte_t port_d_pin_i,
    output pioc_pkg::pioc_byte_t      port_b_pin_o,
    output pioc_pkg::pioc_byte_t      port_b_pin_oe_o,
    output pioc_pkg::pioc_byte_t      port_b_pull_en_o,
    output pioc_pkg::pioc_byte_t      port_c_pin_o,
    output pioc_pkg::pioc_byte_t      port_c_pin_oe_o,
    output pioc_pkg::pioc_byte_t      port_c_pull_en_o,
    output pioc_pkg::pioc_byte_t      port_d_pin_o,
    output pioc_pkg::pioc_byte_t      port_d_pin_oe_o,
    output pioc_pkg::pioc_byte_t      port_d_pull_en_o,
    output pioc_pkg::pioc_byte_t      port_a_skip_o,
    output pioc_pkg::pioc_byte_t      port_b_skip_o,
    output logic [`PIOC_XBAR_C_BITS-1:0] port_c_skip_o
);
    pioc_pkg::pioc_byte_t port_b_data_latch_reg;
    pioc_pkg::pioc_byte_t port_c_data_latch_reg;
    pioc_pkg::pioc_byte_t port_d_data_latch_reg;
    pioc_pkg::pioc_byte_t port_b_output_mode_reg;
    pioc_pkg::pioc_byte_t port_c_output_mode_reg;
    pioc_pkg::pioc_byte_t port_a_crossbar_skip_reg;
    pioc_pkg::pioc_byte_t port_b_crossbar_skip_reg;
    pioc_pkg::pioc_byte_t port_c_crossbar_skip_reg;
    pioc_pkg::pioc_byte_t port_b_input_mode_reg;
    pioc_pkg::pioc_byte_t port_c_input_mode_reg;
    pioc_pkg::pioc_byte_t port_b_sync;
    pioc_pkg::pioc_byte_t port_c_sync;
    pioc_pkg::pioc_byte_t port_d_sync;
    pioc_pkg::pioc_byte_t port_b_read;
    pioc_pkg::pioc_byte_t port_c_read;
    pioc_pkg::pioc_byte_t port_d_read;
    pioc_pkg::pioc_byte_t rdata_next;
    logic                 hit_next;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // address decode
    wire sel_b_data  = sfr_addr_i == `PIOC_ADDR_PORT_B_DATA;
    wire sel_c_data  = sfr_addr_i == `PIOC_ADDR_PORT_C_DATA;
    wire sel_d_data  = sfr_addr_i == `PIOC_ADDR_PORT_D_DATA;
    wire sel_b_omode = sfr_addr_i == `PIOC_ADDR_PORT_B_OMODE;
    wire sel_c_omode = sfr_addr_i == `PIOC_ADDR_PORT_C_OMODE;
    wire sel_a_skip  = sfr_addr_i == `PIOC_ADDR_PORT_A_SKIP;
    wire sel_b_skip  = sfr_addr_i == `PIOC_ADDR_PORT_B_SKIP;
    wire sel_c_skip  = sfr_addr_i == `PIOC_ADDR_PORT_C_SKIP;
    wire sel_b_imode = sfr_addr_i == `PIOC_ADDR_PORT_B_IMODE;
    wire sel_c_imode = sfr_addr_i == `PIOC_ADDR_PORT_C_IMODE;
    wire sel_any     = sel_b_data | sel_c_data | sel_d_data | sel_b_omode
                     | sel_c_omode | sel_a_skip | sel_b_skip | sel_c_skip
                     | sel_b_imode | sel_c_imode;

    // pin levels cross into the clock domain first
    pioc_sync2 #(.W(8)) u_sync_b (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  (port_b_pin_i),
        .sync_o   (port_b_sync)
    );
    pioc_sync2 #(.W(8)) u_sync_c (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  (port_c_pin_i),
        .sync_o   (port_c_sync)
    );
    pioc_sync2 #(.W(8)) u_sync_d (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  (port_d_pin_i),
        .sync_o   (port_d_sync)
    );

    // pin readback: analog reads one, rmw reads the latch
    assign port_b_read = sfr_rmw_i ? port_b_data_latch_reg
                       : (port_b_sync | ~port_b_input_mode_reg);
    assign port_c_read = sfr_rmw_i ? port_c_data_latch_reg
                       : (port_c_sync | ~port_c_input_mode_reg);
    assign port_d_read = sfr_rmw_i ? port_d_data_latch_reg
                       : (port_d_sync | ~port_d_input_mode_i);

    assign rdata_next = sel_b_data  ? port_b_read :
                        sel_c_data  ? port_c_read :
                        sel_d_data  ? port_d_read :
                        sel_b_omode ? port_b_output_mode_reg :
                        sel_c_omode ? port_c_output_mode_reg :
                        sel_a_skip  ? port_a_crossbar_skip_reg :
                        sel_b_skip  ? port_b_crossbar_skip_reg :
                        sel_c_skip  ? port_c_crossbar_skip_reg :
                        sel_b_imode ? port_b_input_mode_reg :
                        sel_c_imode ? port_c_input_mode_reg : `PIOC_RST_READ;
    assign hit_next   = sfr_rd_i && sel_any;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sfr_rdata_o <= `PIOC_RST_READ;
            sfr_hit_o   <= 1'b0;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= rdata_next;
            sfr_hit_o   <= hit_next;
        end else begin
            sfr_hit_o   <= 1'b0;
        end
    end

    // data latches
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_b_data_latch_reg <= `PIOC_RST_DATA;
            port_c_data_latch_reg <= `PIOC_RST_DATA;
            port_d_data_latch_reg <= `PIOC_RST_DATA;
        end else if (sfr_wr_i) begin
            if (sel_b_data) port_b_data_latch_reg <= sfr_wdata_i;
            if (sel_c_data) port_c_data_latch_reg <= sfr_wdata_i;
            if (sel_d_data) port_d_data_latch_reg <= sfr_wdata_i;
        end
    end

    // mode registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_b_output_mode_reg <= `PIOC_RST_OMODE;
            port_c_output_mode_reg <= `PIOC_RST_OMODE;
            port_b_input_mode_reg  <= `PIOC_RST_IMODE;
            port_c_input_mode_reg  <= `PIOC_RST_IMODE;
        end else if (sfr_wr_i) begin
            if (sel_b_omode) port_b_output_mode_reg <= sfr_wdata_i;
            if (sel_c_omode) port_c_output_mode_reg <= sfr_wdata_i;
            if (sel_b_imode) port_b_input_mode_reg  <= sfr_wdata_i;
            if (sel_c_imode) port_c_input_mode_reg  <= sfr_wdata_i;
        end
    end

    // skip registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_a_crossbar_skip_reg <= `PIOC_RST_SKIP;
            port_b_crossbar_skip_reg <= `PIOC_RST_SKIP;
            port_c_crossbar_skip_reg <= `PIOC_RST_SKIP;
        end else if (sfr_wr_i) begin
            if (sel_a_skip) port_a_crossbar_skip_reg <= sfr_wdata_i;
            if (sel_b_skip) port_b_crossbar_skip_reg <= sfr_wdata_i;
            if (sel_c_skip) port_c_crossbar_skip_reg <= sfr_wdata_i;
        end
    end

    // skip masks to the crossbar decoder; port c upper bits not routed
    assign port_a_skip_o = port_a_crossbar_skip_reg;
    assign port_b_skip_o = port_b_crossbar_skip_reg;
    assign port_c_skip_o = port_c_crossbar_skip_reg[`PIOC_XBAR_C_BITS-1:0];

    pioc_port_drv #(
        .PIN_MASK  (PORT_B_PIN_MASK),
        .XBAR_MASK (`PIOC_ALL_PIN_MASK)
    ) u_drv_b (
        .clk_i         (clk_i),
        .arst_n_i      (arst_n_i),
        .latch_i       (port_b_data_latch_reg),
        .in_mode_i     (port_b_input_mode_reg),
        .out_mode_i    (port_b_output_mode_reg),
        .xbar_en_i     (crossbar_enable_bit_i),
        .periph_sel_i  (port_b_periph_sel_i),
        .periph_dout_i (port_b_periph_dout_i),
        .pin_o         (port_b_pin_o),
        .pin_oe_o      (port_b_pin_oe_o),
        .pull_en_o     (port_b_pull_en_o)
    );

    pioc_port_drv #(
        .PIN_MASK  (`PIOC_ALL_PIN_MASK),
        .XBAR_MASK (~`PIOC_UPPER_C_MASK)
    ) u_drv_c (
        .clk_i         (clk_i),
        .arst_n_i      (arst_n_i),
        .latch_i       (port_c_data_latch_reg),
        .in_mode_i     (port_c_input_mode_reg),
        .out_mode_i    (port_c_output_mode_reg),
        .xbar_en_i     (crossbar_enable_bit_i),
        .periph_sel_i  (port_c_periph_sel_i),
        .periph_dout_i (port_c_periph_dout_i),
        .pin_o         (port_c_pin_o),
        .pin_oe_o      (port_c_pin_oe_o),
        .pull_en_o     (port_c_pull_en_o)
    );

    // port d has no crossbar path
    pioc_port_drv #(
        .PIN_MASK  (PORT_D_PIN_MASK),
        .XBAR_MASK (8'h00)
    ) u_drv_d (
        .clk_i         (clk_i),
        .arst_n_i      (arst_n_i),
        .latch_i       (port_d_data_latch_reg),
        .in_mode_i     (port_d_input_mode_i),
        .out_mode_i    (port_d_output_mode_i),
        .xbar_en_i     (crossbar_enable_bit_i),
        .periph_sel_i  (8'h00),
        .periph_dout_i (8'h00),
        .pin_o         (port_d_pin_o),
        .pin_oe_o      (port_d_pin_oe_o),
        .pull_en_o     (port_d_pull_en_o)
    );

    wire wr_a_skip = sfr_wr_i && sel_a_skip;
    wire wr_d_data = sfr_wr_i && sel_d_data;
    wire rd_b_pin  = sfr_rd_i && sel_b_data && !sfr_rmw_i;

    sequence skip_write_s;
        wr_a_skip;
    endsequence
    sequence quiet_d_s;
        !wr_d_data && crossbar_enable_bit_i;
    endsequence

    skip_readback_a: assert property (
        skip_write_s ##1 (sfr_rd_i && sel_a_skip && !sfr_wr_i)
        |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
        else $error("skip register readback differs from write");
    skip_drive_a: assert property (
        skip_write_s |=> port_a_skip_o == $past(sfr_wdata_i))
        else $error("skip mask output not updated by write");
    latch_drive_a: assert property (
        wr_d_data ##1 quiet_d_s
        |=> ((port_d_pin_o ^ $past(sfr_wdata_i, 2)) & port_d_pin_oe_o) == 8'h00)
        else $error("port d pin drives a value other than the latch");
    open_drain_a: assert property (
        (port_b_pin_oe_o & port_b_pin_o & ~$past(port_b_output_mode_reg)
         & ~$past(port_b_periph_sel_i)) == 8'h00)
        else $error("open-drain pin driven high");
    analog_read_a: assert property (
        rd_b_pin |=> (~$past(port_b_input_mode_reg) & ~sfr_rdata_o) == 8'h00)
        else $error("analog pin did not read as one");
    digital_read_a: assert property (
        rd_b_pin |=> ((sfr_rdata_o ^ $past(port_b_sync)) & $past(port_b_input_mode_reg))
                     == 8'h00)
        else $error("digital pin read differs from sampled level");
    analog_undriven_a: assert property (
        ((port_c_pin_oe_o | port_c_pull_en_o) & ~$past(port_c_input_mode_reg)) == 8'h00)
        else $error("analog pin has driver or pullup on");
    push_pull_a: assert property (
        (crossbar_enable_bit_i && port_b_input_mode_reg[0] && port_b_output_mode_reg[0]
         && !port_b_periph_sel_i[0] && PORT_B_PIN_MASK[0])
        |=> port_b_pin_oe_o[0] && port_b_pin_o[0] == $past(port_b_data_latch_reg[0]))
        else $error("push-pull pin not driven from latch");
    upper_c_latch_a: assert property (
        ((port_c_pin_o ^ $past(port_c_data_latch_reg)) & port_c_pin_oe_o
         & `PIOC_UPPER_C_MASK) == 8'h00)
        else $error("port c upper pin taken by crossbar");
    no_pin_d_a: assert property (
        (port_d_pin_oe_o & ~PORT_D_PIN_MASK) == 8'h00)
        else $error("port d drives a bit with no pin");
    rmw_latch_a: assert property (
        (sfr_rd_i && sfr_rmw_i && sel_c_data) |=> sfr_rdata_o == $past(port_c_data_latch_reg))
        else $error("rmw read did not return the latch");
    xbar_off_a: assert property (
        !crossbar_enable_bit_i |=> (port_b_pin_oe_o | port_c_pin_oe_o | port_d_pin_oe_o)
                                   == 8'h00)
        else $error("driver enabled while crossbar disabled");
endmodule

// File: pkg/pioc_defines.svh
// Purpose: register offsets, reset values and widths of the port bank
// Assumes: byte-wide special function register bus
// Notes:   offsets are the bus addresses seen by the core
`ifndef PIOC_DEFINES_SVH
`define PIOC_DEFINES_SVH

`define PIOC_ADDR_PORT_B_DATA   8'h90
`define PIOC_ADDR_PORT_C_DATA   8'ha0
`define PIOC_ADDR_PORT_B_OMODE  8'ha5
`define PIOC_ADDR_PORT_C_OMODE  8'ha6
`define PIOC_ADDR_PORT_D_DATA   8'hb0
`define PIOC_ADDR_PORT_A_SKIP   8'hd4
`define PIOC_ADDR_PORT_B_SKIP   8'hd5
`define PIOC_ADDR_PORT_C_SKIP   8'hd6
`define PIOC_ADDR_PORT_B_IMODE  8'hf2
`define PIOC_ADDR_PORT_C_IMODE  8'hf3

`define PIOC_RST_DATA           8'hff
`define PIOC_RST_OMODE          8'h00
`define PIOC_RST_SKIP           8'h00
`define PIOC_RST_IMODE          8'hff
`define PIOC_RST_READ           8'h00

`define PIOC_XBAR_C_BITS        4
`define PIOC_PORT_D_PIN_MASK    8'h1f
`define PIOC_ALL_PIN_MASK       8'hff
`define PIOC_UPPER_C_MASK       8'hf0

`endif

// File: pkg/pioc_pkg.sv
// Purpose: shared types of the port bank
// Assumes: pioc_defines.svh holds the numbers
// Notes:   none
package pioc_pkg;
    typedef logic [7:0] pioc_byte_t;
endpackage

// File: hw/pioc_sync2.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs asynchronous to clk_i
// Notes:   first stage read only by the second
`timescale 1ns/10ps
module pioc_sync2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule

// File: hw/pioc_port_drv.sv
// Purpose: per-pin output driver control of one port
// Assumes: latch and mode registers on the same clock
// Notes:   outputs registered; one cycle after their causes
`timescale 1ns/10ps
module pioc_port_drv #(
    parameter logic [7:0] PIN_MASK  = 8'hff,
    parameter logic [7:0] XBAR_MASK = 8'hff
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire pioc_pkg::pioc_byte_t latch_i,
    input  wire pioc_pkg::pioc_byte_t in_mode_i,
    input  wire pioc_pkg::pioc_byte_t out_mode_i,
    input  wire logic             xbar_en_i,
    input  wire pioc_pkg::pioc_byte_t periph_sel_i,
    input  wire pioc_pkg::pioc_byte_t periph_dout_i,
    output pioc_pkg::pioc_byte_t  pin_o,
    output pioc_pkg::pioc_byte_t  pin_oe_o,
    output pioc_pkg::pioc_byte_t  pull_en_o
);
    pioc_pkg::pioc_byte_t data_w;
    pioc_pkg::pioc_byte_t oe_w;
    pioc_pkg::pioc_byte_t out_w;
    pioc_pkg::pioc_byte_t pull_w;

    for (genvar i = 0; i < 8; i++) begin : g_pin
        // peripheral takes the pin only where the crossbar reaches it
        assign data_w[i] = (XBAR_MASK[i] && periph_sel_i[i]) ? periph_dout_i[i]
                                                             : latch_i[i];
        // drive low always on pins in PIN_MASK while crossbar enabled, high only when push-pull; analog never
        assign oe_w[i]   = PIN_MASK[i] && xbar_en_i && in_mode_i[i]
                           && (!data_w[i] || out_mode_i[i]);
        assign out_w[i]  = oe_w[i] && data_w[i];
        // analog pins lose the pullup, as do pins driving low
        assign pull_w[i] = PIN_MASK[i] && in_mode_i[i] && !(oe_w[i] && !data_w[i]);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_o     <= 8'h00;
            pin_oe_o  <= 8'h00;
            pull_en_o <= 8'h00;
        end else begin
            pin_o     <= out_w;
            pin_oe_o  <= oe_w;
            pull_en_o <= pull_w;
        end
    end
endmodule

// File: tb/pioc_pin_model.sv
// Purpose: pad model of one port with external source and pullups
// Assumes: bench never drives a pad that the device drives
// Notes:   an undriven pad without pullup toggles each cycle
`timescale 1ns/10ps
module pioc_pin_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pull_i,
    input  wire logic       ext_en_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pad_o
);
    logic [7:0] float_reg = 8'h55;
    logic [7:0] ext_en_w;
    always @(posedge clk_i) begin
        float_reg <= ~float_reg;
    end
    assign ext_en_w = {8{ext_en_i}};
    // device driver first, then external source, then pullup or floating
    assign pad_o = (oe_i & pin_o_i)
                 | (~oe_i & ((ext_en_w & ext_i) | (~ext_en_w & (pull_i | float_reg))));
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench of the port bank
// Assumes: default pin masks, one clock of 10 MHz
// Notes:   random stimulus from a fixed seed
`timescale 1ns/10ps
`include "pioc_defines.svh"
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
module tb;
    logic clk = 0, arst_n = 0, wr = 0, rd = 0, rmw = 0, xbar = 0, ext_en = 0, h;
    logic [7:0] addr = 0, wdata = 0, dmi = 8'hff, dmo = 0, bsel = 0, bdout = 0;
    logic [7:0] csel = 0, cdout = 0, ext_b = 0, ext_c = 0, ext_d = 0, d;
    logic [7:0] imb, omb, imc, omc, lb, lc, ld, vb, vc, v;
    pioc_pkg::pioc_byte_t rdata, bo, boe, bpu, co, coe, cpu, do_, doe, dpu, askip, bskip;
    pioc_pkg::pioc_byte_t pad_b, pad_c, pad_d;
    logic [3:0] cskip;
    int mismatches = 0, n_tests = 0, seed = 1352;
    logic [7:0] rw_addr [6] = '{`PIOC_ADDR_PORT_A_SKIP, `PIOC_ADDR_PORT_B_SKIP,
        `PIOC_ADDR_PORT_C_SKIP, `PIOC_ADDR_PORT_B_OMODE, `PIOC_ADDR_PORT_C_OMODE,
        `PIOC_ADDR_PORT_B_IMODE};
    always #50 clk = ~clk;
    pioc_port_bank uut (.clk_i(clk), .arst_n_i(arst_n), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rmw_i(rmw), .sfr_rdata_o(rdata),
        .sfr_hit_o(h), .crossbar_enable_bit_i(xbar), .port_d_input_mode_i(dmi),
        .port_d_output_mode_i(dmo), .port_b_periph_sel_i(bsel), .port_b_periph_dout_i(bdout),
        .port_c_periph_sel_i(csel), .port_c_periph_dout_i(cdout), .port_b_pin_i(pad_b),
        .port_c_pin_i(pad_c), .port_d_pin_i(pad_d), .port_b_pin_o(bo), .port_b_pin_oe_o(boe),
        .port_b_pull_en_o(bpu), .port_c_pin_o(co), .port_c_pin_oe_o(coe),
        .port_c_pull_en_o(cpu), .port_d_pin_o(do_), .port_d_pin_oe_o(doe),
        .port_d_pull_en_o(dpu), .port_a_skip_o(askip), .port_b_skip_o(bskip),
        .port_c_skip_o(cskip));
    pioc_pin_model pm_b (.clk_i(clk), .pin_o_i(bo), .oe_i(boe), .pull_i(bpu),
        .ext_en_i(ext_en), .ext_i(ext_b), .pad_o(pad_b));
    pioc_pin_model pm_c (.clk_i(clk), .pin_o_i(co), .oe_i(coe), .pull_i(cpu),
        .ext_en_i(ext_en), .ext_i(ext_c), .pad_o(pad_c));
    pioc_pin_model pm_d (.clk_i(clk), .pin_o_i(do_), .oe_i(doe), .pull_i(dpu),
        .ext_en_i(ext_en), .ext_i(ext_d), .pad_o(pad_d));
    function automatic logic [7:0] exp_oe(input logic [7:0] v, im, om, m, input logic x);
        return m & im & {8{x}} & (~v | om);
    endfunction
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk);
        addr <= a;
        wdata <= dv;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic m);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        rmw <= m;
        @(posedge clk);
        rd <= 0;
        rmw <= 0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic m, input logic [7:0] e);
        rd_reg(a, m);
        `CHK(d, e, "read value")
        `CHK(h, 1'b1, "hit flag")
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #3000000;
        mismatches++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1;
        for (int i = 0; i < 6; i++)
            chk_reg(rw_addr[i], 0, i == 5 ? 8'hff : 8'h00);
        chk_reg(`PIOC_ADDR_PORT_C_IMODE, 0, 8'hff);
        chk_reg(`PIOC_ADDR_PORT_B_DATA, 1, 8'hff);
        chk_reg(`PIOC_ADDR_PORT_C_DATA, 1, 8'hff);
        chk_reg(`PIOC_ADDR_PORT_D_DATA, 1, 8'hff);
        rd_reg(8'h00, 0);
        `CHK(d, 8'h00, "unmapped data")
        `CHK(h, 1'b0, "unmapped hit")
        $display("test reset_values done");
        repeat (16) begin
            v = $random(seed);
            for (int i = 0; i < 6; i++)
                wr_reg(rw_addr[i], v ^ i[7:0]);
            for (int i = 0; i < 6; i++)
                chk_reg(rw_addr[i], 0, v ^ i[7:0]);
            `CHK(askip, v, "skip a out")
            `CHK(bskip, v ^ 8'h01, "skip b out")
            `CHK(cskip, v[3:0] ^ 4'h2, "skip c out")
            @(posedge clk);
            addr <= `PIOC_ADDR_PORT_A_SKIP;
            wdata <= ~v;
            wr <= 1;
            @(posedge clk);
            wr <= 0;
            rd <= 1;
            @(posedge clk);
            rd <= 0;
            @(negedge clk);
            `CHK(rdata, ~v, "back to back read")
            `CHK(h, 1'b1, "back to back hit")
            `CHK(askip, ~v, "skip a update")
        end
        $display("test register_readback done");
        for (int k = 0; k < 24; k++) begin
            {imb, omb, imc, omc} = {$random(seed)};
            {lb, lc, ld, v} = {$random(seed)};
            wr_reg(`PIOC_ADDR_PORT_B_IMODE, imb);
            wr_reg(`PIOC_ADDR_PORT_B_OMODE, omb);
            wr_reg(`PIOC_ADDR_PORT_B_SKIP, ~imb | ~`PIOC_ALL_PIN_MASK);
            wr_reg(`PIOC_ADDR_PORT_C_IMODE, imc);
            wr_reg(`PIOC_ADDR_PORT_C_OMODE, omc);
            wr_reg(`PIOC_ADDR_PORT_C_SKIP, ~imc);
            wr_reg(`PIOC_ADDR_PORT_B_DATA, lb);
            wr_reg(`PIOC_ADDR_PORT_C_DATA, lc);
            wr_reg(`PIOC_ADDR_PORT_D_DATA, ld);
            bsel <= v & imb;
            csel <= ~v & imc;
            {bdout, cdout, dmi, dmo} <= {$random(seed)};
            xbar <= (k % 4) != 0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            vb = (bsel & bdout) | (~bsel & lb);
            vc = (csel & 8'h0f & cdout) | (~(csel & 8'h0f) & lc);
            `CHK(boe, exp_oe(vb, imb, omb, 8'hff, xbar), "oe b")
            `CHK(bo, vb & exp_oe(vb, imb, omb, 8'hff, xbar), "pin b")
            `CHK(coe, exp_oe(vc, imc, omc, 8'hff, xbar), "oe c")
            `CHK(co, vc & exp_oe(vc, imc, omc, 8'hff, xbar), "pin c")
            `CHK(doe, exp_oe(ld, dmi, dmo, 8'h1f, xbar), "oe d")
            `CHK(do_, ld & exp_oe(ld, dmi, dmo, 8'h1f, xbar), "pin d")
            `CHK(bpu & ~imb, 8'h00, "pull on analog b")
            `CHK(cpu, imc & ~(exp_oe(vc, imc, omc, 8'hff, xbar) & ~vc), "pull c")
            `CHK(dpu, 8'h1f & dmi & ~(exp_oe(ld, dmi, dmo, 8'h1f, xbar) & ~ld), "pull d")
            chk_reg(`PIOC_ADDR_PORT_D_DATA, 1, ld);
        end
        $display("test pin_drive done");
        @(posedge clk);
        xbar <= 0;
        ext_en <= 1;
        repeat (16) begin
            {imb, imc} = 16'($random(seed));
            wr_reg(`PIOC_ADDR_PORT_B_IMODE, imb);
            {ext_b, ext_c, ext_d, dmi} <= {$random(seed)};
            wr_reg(`PIOC_ADDR_PORT_C_IMODE, imc);
            repeat (4) @(negedge clk);
            `CHK(boe | coe | doe, 8'h00, "drivers off")
            rd_reg(`PIOC_ADDR_PORT_B_DATA, 0);
            `CHK(d, ext_b | ~imb, "read b")
            rd_reg(`PIOC_ADDR_PORT_C_DATA, 0);
            `CHK(d, ext_c | ~imc, "read c")
            rd_reg(`PIOC_ADDR_PORT_D_DATA, 0);
            `CHK(d & 8'h1f, (ext_d | ~dmi) & 8'h1f, "read d")
        end
        $display("test pin_read done");
        print_verdict;
    end
endmodule
